//--- verilog/flash_regs_defines.vh
// constants for the flash clock, security and configuration register bank
`ifndef FLASH_REGS_DEFINES_VH
`define FLASH_REGS_DEFINES_VH
`define OFS_CLKDIV 8'h00
`define OFS_SECURITY 8'h01
`define OFS_TEST 8'h02
`define OFS_CONFIG 8'h03
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h05
`define OFS_LINES 8'h06
`define IDX_SPACE_TOP 8'h0f
`define BIT_LOADED 7
`define BIT_PRESCALE 6
`define BIT_BEIE 7
`define BIT_COMMAND_COMPLETE_IRQ_ENABLE 6
`define BIT_KEY_ACCESS_GATE 5
`define KEY_ENABLED 2'h2
`define SEC_UNSECURED 2'h2
`define PRESCALE_RATIO 4'h8
`define MAX_DIVIDE 10'h200
`define IRQ_BE 0
`define IRQ_CC 1
`define IRQ_KEYWR 2
`define IRQ_DIVWR 3
`endif

//--- verilog/flash_clock_security_config_regs.v
// flash clock divider, security, test and configuration registers on ahb-lite
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "flash_regs_defines.vh"
module flash_clock_security_config_regs #(
    parameter DIV_WIDTH = 6
)
(
    input wire mclk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [7:0] securityByte,
    input wire securityLoad,
    input wire backdoorUnsecure,
    input wire commandBufferEmptyFlag,
    input wire commandCompleteFlag,
    input wire arrayWrite,
    output wire commandSequenceStart,
    output wire backdoorKeyCapture,
    output wire arrayReadInvalid,
    output reg flashTimingTick,
    output wire keyAccessEnabled,
    output wire chipUnsecured,
    output wire flashIrq,
    output wire eventIrq
);
    reg dividerLoaded;
    reg prescaleByEight;
    reg [DIV_WIDTH-1:0] dividerValue;
    reg [7:0] securityState;
    reg bufferEmptyIrqEnable;
    reg commandCompleteIrqEnable;
    reg keyAccessGate;
    reg [3:0] irqStatus;
    reg [3:0] irqMask;
    reg [2:0] prescaleCount;
    reg [DIV_WIDTH-1:0] divideCount;
    reg dataPhase;
    reg dataWrite;
    reg [7:0] dataAddr;
    reg [31:0] next_hrdata;
    wire take;
    wire writeHit;
    wire [7:0] wbyte;
    wire prescaleTick;
    wire [3:0] events;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && htrans[1] && hready;
    assign writeHit = dataPhase && dataWrite;
    assign wbyte = hwdata[7:0];
    // address phase latched, write done in data phase
    always @(posedge mclk)
    begin
        if (rst)
        begin
            dataPhase <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr <= 8'h00;
        end
        else
        begin
            dataPhase <= take;
            dataWrite <= take && hwrite;
            dataAddr <= haddr[9:2];
        end
    end
    // divider: one-shot write, bit 7 is the hardware-owned loaded flag
    always @(posedge mclk)
    begin
        if (rst)
        begin
            dividerLoaded <= 1'b0;
            prescaleByEight <= 1'b0;
            dividerValue <= {DIV_WIDTH{1'b0}};
        end
        else if (writeHit && dataAddr == `OFS_CLKDIV && !dividerLoaded)
        begin
            dividerLoaded <= 1'b1;
            prescaleByEight <= wbyte[`BIT_PRESCALE];
            dividerValue <= wbyte[DIV_WIDTH-1:0];
        end
    end
    // security byte is sampled while reset is held; no bus path writes it
    always @(posedge mclk)
    begin
        if (rst && securityLoad)
        begin
            securityState <= securityByte;
        end
        else if (rst)
        begin
            securityState <= securityState;
        end
        else if (backdoorUnsecure)
        begin
            securityState[1:0] <= `SEC_UNSECURED;
        end
    end
    assign keyAccessEnabled = securityState[7:6] == `KEY_ENABLED;
    assign chipUnsecured = securityState[1:0] == `SEC_UNSECURED;
    // configuration: three live bits, the key gate guarded by key enable
    always @(posedge mclk)
    begin
        if (rst)
        begin
            bufferEmptyIrqEnable <= 1'b0;
            commandCompleteIrqEnable <= 1'b0;
            keyAccessGate <= 1'b0;
        end
        else if (writeHit && dataAddr == `OFS_CONFIG)
        begin
            bufferEmptyIrqEnable <= wbyte[`BIT_BEIE];
            commandCompleteIrqEnable <= wbyte[`BIT_COMMAND_COMPLETE_IRQ_ENABLE];
            if (keyAccessEnabled)
            begin
                keyAccessGate <= wbyte[`BIT_KEY_ACCESS_GATE];
            end
        end
    end
    assign commandSequenceStart = arrayWrite && !keyAccessGate;
    assign backdoorKeyCapture = arrayWrite && keyAccessGate;
    assign arrayReadInvalid = keyAccessGate;
    assign flashIrq = (bufferEmptyIrqEnable && commandBufferEmptyFlag)
        || (commandCompleteIrqEnable && commandCompleteFlag);
    // timebase: 8 x 64 caps the ratio at 512; runs only once loaded
    assign prescaleTick = !prescaleByEight || prescaleCount == 3'h7;
    always @(posedge mclk)
    begin
        if (rst || !dividerLoaded)
        begin
            prescaleCount <= 3'h0;
            divideCount <= {DIV_WIDTH{1'b0}};
            flashTimingTick <= 1'b0;
        end
        else
        begin
            prescaleCount <= prescaleByEight ? prescaleCount + 3'h1 : 3'h0;
            flashTimingTick <= 1'b0;
            if (prescaleTick)
            begin
                if (divideCount >= dividerValue)
                begin
                    divideCount <= {DIV_WIDTH{1'b0}};
                    flashTimingTick <= 1'b1;
                end
                else
                begin
                    divideCount <= divideCount + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
    // sticky event bits; a new event beats a same-cycle clear
    assign events = {writeHit && dataAddr == `OFS_CLKDIV && !dividerLoaded,
        backdoorKeyCapture, commandCompleteFlag, commandBufferEmptyFlag};
    always @(posedge mclk)
    begin
        if (rst)
        begin
            irqStatus <= 4'h0;
            irqMask <= 4'h0;
        end
        else
        begin
            if (writeHit && dataAddr == `OFS_IRQ_MASK)
            begin
                irqMask <= wbyte[3:0];
            end
            if (writeHit && dataAddr == `OFS_IRQ_STATUS)
            begin
                irqStatus <= (irqStatus & ~wbyte[3:0]) | events;
            end
            else
            begin
                irqStatus <= irqStatus | events;
            end
        end
    end
    assign eventIrq = |(irqStatus & irqMask);
    // read mux sampled at the address phase; reserved and unmapped read zero
    always @*
    begin
        next_hrdata = 32'h00000000;
        case (haddr[9:2])
            `OFS_CLKDIV: next_hrdata[7:0] = {dividerLoaded, prescaleByEight, dividerValue};
            `OFS_SECURITY: next_hrdata[7:0] = securityState;
            `OFS_TEST: next_hrdata = 32'h00000000;
            `OFS_CONFIG: next_hrdata[7:0] = {bufferEmptyIrqEnable,
                commandCompleteIrqEnable, keyAccessGate, 5'h00};
            `OFS_IRQ_STATUS: next_hrdata[3:0] = irqStatus;
            `OFS_IRQ_MASK: next_hrdata[3:0] = irqMask;
            `OFS_LINES: next_hrdata[1:0] = {chipUnsecured, keyAccessEnabled};
            default: next_hrdata = 32'h00000000;
        endcase
    end
    always @(posedge mclk)
    begin
        if (rst)
        begin
            hrdata <= 32'h00000000;
        end
        else if (take && !hwrite)
        begin
            hrdata <= next_hrdata;
        end
    end
endmodule

//--- testbench/flash_regs_monitor.sv
// assertion checker for the flash register bank ports
`timescale 1ns/100ps
module flash_regs_monitor (
    input wire mclk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire backdoorUnsecure,
    input wire commandBufferEmptyFlag,
    input wire commandCompleteFlag,
    input wire arrayWrite,
    input wire commandSequenceStart,
    input wire backdoorKeyCapture,
    input wire arrayReadInvalid,
    input wire keyAccessEnabled,
    input wire chipUnsecured,
    input wire flashIrq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire rdTake = hsel & htrans[1] & hready & !hwrite;
    a_zero_wait: assert property (hreadyout && !hresp) else $error("bus stalled or error");
    a_test_zero: assert property (rdTake && haddr == 32'h8 |=> hrdata == 32'h0)
        else $error("test register read nonzero");
    a_key_decode: assert property (rdTake && haddr == 32'h4 |=>
        keyAccessEnabled == (hrdata[7:6] == 2'h2)) else $error("key enable decode");
    a_sec_decode: assert property (rdTake && haddr == 32'h4 |=>
        chipUnsecured == (hrdata[1:0] == 2'h2)) else $error("security decode");
    a_unsec_force: assert property ($past(backdoorUnsecure) |-> chipUnsecured)
        else $error("unsecure not forced");
    a_gate_rise: assert property ($rose(arrayReadInvalid) |-> $past(keyAccessEnabled))
        else $error("key gate set while disabled");
    a_seq_start: assert property (commandSequenceStart == (arrayWrite && !arrayReadInvalid))
        else $error("command start wrong");
    a_key_capture: assert property (backdoorKeyCapture == (arrayWrite && arrayReadInvalid))
        else $error("key capture wrong");
    a_irq_quiet: assert property (!commandBufferEmptyFlag && !commandCompleteFlag |-> !flashIrq)
        else $error("irq without flag");
endmodule
bind flash_clock_security_config_regs flash_regs_monitor u_flash_regs_monitor (.mclk, .rst, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .backdoorUnsecure,
    .commandBufferEmptyFlag, .commandCompleteFlag, .arrayWrite, .commandSequenceStart,
    .backdoorKeyCapture, .arrayReadInvalid, .keyAccessEnabled, .chipUnsecured, .flashIrq);

//--- testbench/tb_top.sv
// self-checking bench for the flash register bank
`timescale 1ns/100ps
module tb_top;
    reg mclk = 0, rst = 1, hsel = 0, hwrite = 0, securityLoad = 1, backdoorUnsecure = 0;
    reg commandBufferEmptyFlag = 0, commandCompleteFlag = 0, arrayWrite = 0;
    reg [31:0] haddr = 0, hwdata = 0, rd;
    reg [1:0] htrans = 0;
    reg [2:0] hsize = 3'h2;
    reg [7:0] securityByte = 8'ha6;
    wire [31:0] hrdata;
    wire hreadyout, hresp, commandSequenceStart, backdoorKeyCapture, arrayReadInvalid;
    wire flashTimingTick, keyAccessEnabled, chipUnsecured, flashIrq, eventIrq;
    integer fails = 0, n_checks = 0, cyc = 0, i, t;
    // rows: write, address, data, read mask, expected
    reg [32:0] rows [13] = '{{1'b0,32'h00008000}, {1'b1,32'h00ff0000}, {1'b0,32'h0000ffff},
        {1'b1,32'h00000000}, {1'b0,32'h0000ffff}, {1'b1,32'h04000000}, {1'b0,32'h0400ffa6},
        {1'b1,32'h08ff0000}, {1'b0,32'h0800ff00}, {1'b1,32'h0cff0000}, {1'b0,32'h0c00ffe0},
        {1'b1,32'h20ff0000}, {1'b0,32'h2000ff00}};
    always #2 mclk = ~mclk;
    flash_clock_security_config_regs u_flash_clock_security_config_regs (.mclk, .rst, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .securityByte, .securityLoad, .backdoorUnsecure, .commandBufferEmptyFlag,
        .commandCompleteFlag, .arrayWrite, .commandSequenceStart, .backdoorKeyCapture,
        .arrayReadInvalid, .flashTimingTick, .keyAccessEnabled, .chipUnsecured, .flashIrq,
        .eventIrq);
    task results;
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one word transfer; waits on ready in both phases
    task bus(input w, input [7:0] a, input [7:0] d);
        @(posedge mclk);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge mclk); while (!hreadyout);
        hsel <= 0; htrans <= 2'h0; hwdata <= {24'h0, d};
        do @(posedge mclk); while (!hreadyout);
        rd = hrdata;
        // let the write land before any caller looks at its effect
        #1;
    endtask
    task per;
        @(posedge mclk iff flashTimingTick);
        t = 0;
        do begin @(posedge mclk); t++; end while (!flashTimingTick);
    endtask
    task pins(input [1:0] f, input [7:0] cfg);
        commandBufferEmptyFlag <= f[0]; commandCompleteFlag <= f[1];
        bus(1, 8'h0c, cfg);
        @(posedge mclk);
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            results;
        end
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst <= 0;
        foreach (rows[i])
        begin
            bus(rows[i][32], rows[i][31:24], rows[i][23:16]);
            if (!rows[i][32]) chk("row", rd[7:0] & rows[i][15:8], rows[i][7:0]);
        end
        per; chk("slow period", t, 512);
        arrayWrite <= 1; @(posedge mclk); #1 chk("key capture", backdoorKeyCapture, 1);
        chk("read invalid", arrayReadInvalid, 1);
        arrayWrite <= 0;
        pins(2'h1, 8'h80); chk("empty irq", flashIrq, 1);
        pins(2'h1, 8'h40); chk("empty masked", flashIrq, 0);
        pins(2'h2, 8'h40); chk("done irq", flashIrq, 1);
        bus(1, 8'h14, 8'h02); chk("event irq", eventIrq, 1);
        bus(1, 8'h14, 8'h00); chk("event masked", eventIrq, 0);
        pins(2'h0, 8'h00);
        bus(1, 8'h10, 8'h0f); bus(0, 8'h10, 8'h0); chk("status clear", rd, 0);
        arrayWrite <= 1; @(posedge mclk); #1 chk("cmd start", commandSequenceStart, 1);
        arrayWrite <= 0; rst <= 1; securityByte <= 8'h7d;
        repeat (8) @(posedge mclk);
        rst <= 0;
        bus(0, 8'h00, 8'h0); chk("loaded flag", rd[7], 0);
        bus(0, 8'h04, 8'h0); chk("secured byte", rd, 32'h7d);
        chk("key off", {keyAccessEnabled, chipUnsecured}, 0);
        bus(1, 8'h0c, 8'h20); bus(0, 8'h0c, 8'h0); chk("gate refused", rd, 0);
        backdoorUnsecure <= 1;
        bus(0, 8'h04, 8'h0); chk("forced", rd, 32'h7e);
        bus(1, 8'h00, 8'h02); per; chk("fast period", t, 3);
        results;
    end
endmodule
